//--- verilog/mux_adc_slot_pkg.sv
// package: register map, field layout and types of the converter sequence slot block
package mux_adc_slot_pkg;

  // bus and word widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;
  localparam int STRB_W = 4;

  // register indexes as printed; byte address is four times the index
  localparam logic [9:0] SLOT12_INDEX = 10'h0dc;
  localparam logic [9:0] SLOT13_INDEX = 10'h0dd;

  // values after reset of the two configuration words
  localparam logic [15:0] SLOT12_RESET = 16'h000c;
  localparam logic [15:0] SLOT13_RESET = 16'h000d;

  // field positions inside a slot configuration word
  localparam int ENABLE_BIT = 15;
  localparam int GAIN_HI = 14;
  localparam int GAIN_LO = 13;
  localparam int NEG_BIT = 4;
  localparam int POS_HI = 3;
  localparam int POS_LO = 0;

  // bits that store a value; bits 12:5 are reserved and stay zero in the slot 12 word, the slot 13 word keeps them
  localparam logic [15:0] SLOT_WRITE_MASK = 16'he01f;

  // gain field codes
  localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
  localparam logic [1:0] GAIN_CODE_X2 = 2'h1;

  // positive input codes: last external input, then internal sources
  localparam logic [3:0] POS_CODE_EXT_LAST = 4'h7;
  localparam logic [3:0] POS_CODE_TEMP = 4'h8;
  localparam logic [3:0] POS_CODE_SHORT = 4'h9;
  localparam logic [3:0] POS_CODE_TEST_DAC = 4'ha;
  localparam logic [3:0] POS_CODE_QUARTER_ANALOG = 4'hb;
  localparam logic [3:0] POS_CODE_HALF_DIGITAL = 4'hc;
  localparam logic [3:0] POS_CODE_ANALOG_POWER_A = 4'hd;
  localparam logic [3:0] POS_CODE_ANALOG_POWER_B = 4'he;
  localparam logic [3:0] POS_CODE_DIGITAL_POWER = 4'hf;

  // bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // converter gain applied during the slot
  typedef enum logic [1:0] {
    GAIN_X1,
    GAIN_X2,
    GAIN_X4
  } gain_t;

  // source on the positive converter input
  typedef enum logic [3:0] {
    POS_EXT0,
    POS_EXT1,
    POS_EXT2,
    POS_EXT3,
    POS_EXT4,
    POS_EXT5,
    POS_EXT6,
    POS_EXT7,
    POS_TEMP_SENSOR,
    POS_GROUND_SHORT,
    POS_TEST_DAC,
    POS_QUARTER_ANALOG_SUPPLY,
    POS_HALF_DIGITAL_SUPPLY,
    POS_ANALOG_POWER_DIV,
    POS_DIGITAL_POWER_DIV
  } pos_source_t;

  // source on the negative converter input
  typedef enum logic [1:0] {
    NEG_GROUND,
    NEG_EXT7,
    NEG_AUTO
  } neg_source_t;

  // decoded routing of one slot toward the sequencer
  typedef struct packed {
    logic enable;
    gain_t gain;
    pos_source_t pos;
    neg_source_t neg;
    logic internal;
  } slot_route_t;

  // routing that a word at its reset value decodes to
  localparam slot_route_t ROUTE_RESET = '{
    enable: 1'b0,
    gain: GAIN_X1,
    pos: POS_HALF_DIGITAL_SUPPLY,
    neg: NEG_AUTO,
    internal: 1'b1
  };

  // byte address of a register index
  function automatic logic [11:0] byte_addr(input logic [9:0] index);
    return {index, 2'b00};
  endfunction : byte_addr

endpackage : mux_adc_slot_pkg

//--- verilog/mux_adc_slot_decode.sv
// decoder from one slot configuration word to converter routing
`timescale 1ns/1ps
`default_nettype none

module mux_adc_slot_decode (
  input wire logic [15:0] config_word_in,
  output var mux_adc_slot_pkg::slot_route_t route_out
);

  // field views of the word
  logic [3:0] pos_code; // positive input code
  logic [1:0] gain_code; // gain code

  assign pos_code = config_word_in[mux_adc_slot_pkg::POS_HI:mux_adc_slot_pkg::POS_LO];
  assign gain_code = config_word_in[mux_adc_slot_pkg::GAIN_HI:mux_adc_slot_pkg::GAIN_LO];

  // pure decode, no state
  always_comb begin
    route_out.enable = config_word_in[mux_adc_slot_pkg::ENABLE_BIT];
    // upper two gain codes both mean four
    case (gain_code)
      mux_adc_slot_pkg::GAIN_CODE_X1: route_out.gain = mux_adc_slot_pkg::GAIN_X1;
      mux_adc_slot_pkg::GAIN_CODE_X2: route_out.gain = mux_adc_slot_pkg::GAIN_X2;
      default: route_out.gain = mux_adc_slot_pkg::GAIN_X4;
    endcase
    // external inputs first, then internal sources
    route_out.internal = (pos_code > mux_adc_slot_pkg::POS_CODE_EXT_LAST);
    case (pos_code)
      mux_adc_slot_pkg::POS_CODE_TEMP: route_out.pos = mux_adc_slot_pkg::POS_TEMP_SENSOR;
      mux_adc_slot_pkg::POS_CODE_SHORT: route_out.pos = mux_adc_slot_pkg::POS_GROUND_SHORT;
      mux_adc_slot_pkg::POS_CODE_TEST_DAC: route_out.pos = mux_adc_slot_pkg::POS_TEST_DAC;
      mux_adc_slot_pkg::POS_CODE_QUARTER_ANALOG: begin
        route_out.pos = mux_adc_slot_pkg::POS_QUARTER_ANALOG_SUPPLY;
      end
      mux_adc_slot_pkg::POS_CODE_HALF_DIGITAL: begin
        route_out.pos = mux_adc_slot_pkg::POS_HALF_DIGITAL_SUPPLY;
      end
      mux_adc_slot_pkg::POS_CODE_ANALOG_POWER_A,
      mux_adc_slot_pkg::POS_CODE_ANALOG_POWER_B: begin
        route_out.pos = mux_adc_slot_pkg::POS_ANALOG_POWER_DIV;
      end
      mux_adc_slot_pkg::POS_CODE_DIGITAL_POWER: begin
        route_out.pos = mux_adc_slot_pkg::POS_DIGITAL_POWER_DIV;
      end
      default: route_out.pos = mux_adc_slot_pkg::pos_source_t'(pos_code);
    endcase
    // internal sources pick their own negative input, bit 4 ignored
    if (route_out.internal) begin
      route_out.neg = mux_adc_slot_pkg::NEG_AUTO;
    end else if (config_word_in[mux_adc_slot_pkg::NEG_BIT]) begin
      route_out.neg = mux_adc_slot_pkg::NEG_EXT7;
    end else begin
      route_out.neg = mux_adc_slot_pkg::NEG_GROUND;
    end
  end

endmodule : mux_adc_slot_decode

`default_nettype wire

//--- verilog/mux_adc_slot_config.sv
// axi4-lite register slave holding the slot 12 and slot 13 configuration words
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module mux_adc_slot_config (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // write address channel
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic [2:0] s_axi_awprot_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // write data channel
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // write response channel
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // read address channel
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic [2:0] s_axi_arprot_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // read data channel
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // toward the sequencer
  output var mux_adc_slot_pkg::slot_route_t slot_route_out,
  output logic [15:0] slot12_config_out,
  output logic [15:0] slot13_config_out
);

  // write path
  // address and data may come together or in either order
  // a lone address or data beat is parked until its partner arrives
  // the word is written on the edge that sees both halves
  // bvalid rises on that same edge and stands until bready
  // no address or data is taken while a response stands
  // an address off the map stores nothing and answers with an error

  // read path
  // rvalid and the answer rise on the same edge that takes the address
  // rvalid stands until rready, with no new address meanwhile
  // an address off the map reads zero with an error
  // reads and writes run side by side, neither waits

  // addressing
  // each register is one 32-bit word, its upper half reads zero
  // bits 1:0 of both addresses are ignored
  // only byte lanes 0 and 1 reach a 16-bit word
  // the slot 13 word sits one word above the slot 12 word

  // toward the sequencer
  // both raw words leave straight from their flops
  // the slot 12 route is decoded and registered once more
  // so it trails a write by one extra cycle
  // reset leaves slot 12 disabled at gain one
  // with its positive input on the half digital supply
  // reset leaves slot 13 on its own default source

  // whole state of the block in one word
  // bus side first, then the stored words and the route
  typedef struct packed {
    logic aw_held; // write address taken, waiting for data
    logic [11:0] aw_addr; // held write address
    logic w_held; // write data taken, waiting for address
    logic [31:0] w_data; // held write data
    logic [3:0] w_strb; // held byte strobes
    logic bvalid; // write response pending
    logic [1:0] bresp; // write response code
    logic rvalid; // read data pending
    logic [31:0] rdata; // read data
    logic [1:0] rresp; // read response code
    logic [15:0] slot12; // slot 12 configuration word
    logic [15:0] slot13; // slot 13 configuration word
    mux_adc_slot_pkg::slot_route_t route; // registered routing of slot 12
  } state_t;

  // state right after reset
  // both words at their reset values, all handshakes idle
  localparam state_t STATE_RESET = '{
    aw_held: 1'b0,
    aw_addr: 12'h000,
    w_held: 1'b0,
    w_data: 32'h0000_0000,
    w_strb: 4'h0,
    bvalid: 1'b0,
    bresp: mux_adc_slot_pkg::RESP_OKAY,
    rvalid: 1'b0,
    rdata: 32'h0000_0000,
    rresp: mux_adc_slot_pkg::RESP_OKAY,
    slot12: mux_adc_slot_pkg::SLOT12_RESET,
    slot13: mux_adc_slot_pkg::SLOT13_RESET,
    route: mux_adc_slot_pkg::ROUTE_RESET
  };

  // one register holds it all; next_state is its input
  state_t state; // registered state
  state_t next_state; // value for the next edge

  // channel handshake terms
  // combinational, from the bus and the held state
  logic aw_take; // write address moves this edge
  logic w_take; // write data moves this edge
  logic ar_take; // read address moves this edge
  logic have_aw; // write address available now
  logic have_w; // write data available now
  logic [11:0] wr_addr; // address of the write being done
  logic [31:0] wr_data; // data of the write being done
  logic [3:0] wr_strb; // strobes of the write being done
  mux_adc_slot_pkg::slot_route_t decoded_route; // live decode of slot 12

  // true when a byte address falls on a register's word
  function automatic logic addr_hit(input logic [11:0] addr, input logic [9:0] index);
    logic [11:0] target; // byte address of the register
    target = mux_adc_slot_pkg::byte_addr(index);
    // low two bits pick a byte inside the word and are ignored
    return addr[11:2] == target[11:2];
  endfunction : addr_hit

  // merge the low two byte lanes into a 16-bit word
  // strobes pick bytes; unselected bytes keep their value
  function automatic logic [15:0] merge_word(
    input logic [15:0] old_word,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [15:0] merged;
    // start from the stored word
    merged = old_word;
    // lane 0 carries bits 7:0
    if (strb[0]) begin
      merged[7:0] = data[7:0];
    end
    // lane 1 carries bits 15:8
    if (strb[1]) begin
      merged[15:8] = data[15:8];
    end
    // lanes 2 and 3 land above the word and are dropped
    return merged;
  endfunction : merge_word

  // slot 12 word decoder
  // only slot 12 is decoded; slot 13 leaves as a raw word
  mux_adc_slot_decode u_decode (
    .config_word_in(state.slot12),
    .route_out(decoded_route)
  );

  // ready terms; address and data are each refused while held or answered
  // a parked half refuses a second one of its kind
  // a standing response refuses both, so one write at most is open
  // arready drops while read data stands, so one read at most is open
  assign s_axi_awready_out = !state.aw_held && !state.bvalid;
  assign s_axi_wready_out = !state.w_held && !state.bvalid;
  assign s_axi_arready_out = !state.rvalid;

  // registered answers
  // all answer outputs come straight from flops
  assign s_axi_bvalid_out = state.bvalid;
  assign s_axi_bresp_out = state.bresp;
  assign s_axi_rvalid_out = state.rvalid;
  assign s_axi_rdata_out = state.rdata;
  assign s_axi_rresp_out = state.rresp;

  // registered configuration toward the sequencer
  // words change on the write edge, the route one edge later
  assign slot_route_out = state.route;
  assign slot12_config_out = state.slot12;
  assign slot13_config_out = state.slot13;

  // handshakes seen this cycle
  // a channel moves when its valid and ready are both high
  assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
  assign w_take = s_axi_wvalid_in && s_axi_wready_out;
  assign ar_take = s_axi_arvalid_in && s_axi_arready_out;

  // address and data either held or arriving now
  // lets a write complete on the edge its second half arrives
  assign have_aw = state.aw_held || aw_take;
  assign have_w = state.w_held || w_take;

  // held values win over the bus; bus values used on the taking edge
  // the master may move its bus lines once its half is taken
  assign wr_addr = state.aw_held ? state.aw_addr : s_axi_awaddr_in;
  assign wr_data = state.w_held ? state.w_data : s_axi_wdata_in;
  assign wr_strb = state.w_held ? state.w_strb : s_axi_wstrb_in;

  // next state of the whole block
  always_comb begin
    // default: every field keeps its value
    next_state = state;
    // branches below touch only the fields that move this cycle

    // follow the decoded word one cycle behind
    next_state.route = decoded_route;
    // the extra flop keeps the decoder off the sequencer's path
    // and makes the route change on a clean edge

    // a parked half is released on the edge that completes the pair
    // capture an address that arrives without its data
    if (aw_take) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr_in;
    end

    // capture data that arrives without its address
    if (w_take) begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata_in;
      next_state.w_strb = s_axi_wstrb_in;
    end

    // both halves present: do the write and answer
    // parked halves win over the bus, so a late partner pairs right
    // the response flag blocks both readies until bready takes it
    if (have_aw && have_w) begin
      next_state.aw_held = 1'b0;
      next_state.w_held = 1'b0;
      next_state.bvalid = 1'b1;
      if (addr_hit(wr_addr, mux_adc_slot_pkg::SLOT12_INDEX)) begin
        // reserved bits are masked off on every write
        // lanes 2 and 3 are dropped inside the merge
        next_state.slot12 = merge_word(state.slot12, wr_data, wr_strb)
          & mux_adc_slot_pkg::SLOT_WRITE_MASK;
        next_state.bresp = mux_adc_slot_pkg::RESP_OKAY;
      end else if (addr_hit(wr_addr, mux_adc_slot_pkg::SLOT13_INDEX)) begin
        // slot 13 layout lives elsewhere; the word is stored whole
        // no reserved mask here, its fields are decoded outside
        next_state.slot13 = merge_word(state.slot13, wr_data, wr_strb);
        next_state.bresp = mux_adc_slot_pkg::RESP_OKAY;
      end else begin
        // unmapped address, nothing stored
        // both words keep their value; only the error code returns
        next_state.bresp = mux_adc_slot_pkg::RESP_SLVERR;
      end
    end else if (state.bvalid && s_axi_bready_in) begin
      // response taken by the master
      // readies rise again on the next cycle
      next_state.bvalid = 1'b0;
    end

    // read: answer on the same edge that takes the address
    // data comes from the stored words, so a write landing on
    // the same edge shows up in the next read, not this one
    if (ar_take) begin
      next_state.rvalid = 1'b1;
      if (addr_hit(s_axi_araddr_in, mux_adc_slot_pkg::SLOT12_INDEX)) begin
        // upper half of the bus reads zero
        // reserved bits are already zero in the stored word
        next_state.rdata = {16'h0000, state.slot12};
        next_state.rresp = mux_adc_slot_pkg::RESP_OKAY;
      end else if (addr_hit(s_axi_araddr_in, mux_adc_slot_pkg::SLOT13_INDEX)) begin
        // second word sits one index above
        next_state.rdata = {16'h0000, state.slot13};
        next_state.rresp = mux_adc_slot_pkg::RESP_OKAY;
      end else begin
        // unmapped address reads zero with an error
        next_state.rdata = 32'h0000_0000;
        next_state.rresp = mux_adc_slot_pkg::RESP_SLVERR;
      end
    end else if (state.rvalid && s_axi_rready_in) begin
      // read data taken by the master
      // arready rises again on the next cycle
      next_state.rvalid = 1'b0;
    end
  end

  // state register with synchronous reset
  // reset loads both words, clears every handshake flag
  // and sets the route to what the reset word decodes to
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // limitations
  // strobes on lanes 2 and 3 are accepted and dropped
  // the protection bits are accepted and ignored
  // one address hits one word, so no write priority is needed

endmodule : mux_adc_slot_config

`default_nettype wire

//--- tb/mux_adc_slot_chk.sv
// checker: slot 12 word against its decoded route and reset values
`timescale 1ns/1ps
`default_nettype none
module mux_adc_slot_chk (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire mux_adc_slot_pkg::slot_route_t slot_route_out,
  input wire logic [15:0] slot12_config_out,
  input wire logic [15:0] slot13_config_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [15:0] w; // word one cycle back, lines up with route
  // delay the word by the route's one-cycle lag
  always_ff @(posedge core_clk_in) begin
    w <= slot12_config_out;
  end
  property p_en;
    slot_route_out.enable == w[15];
  endproperty
  a_en: assert property (p_en) else $error("enable wrong");
  property p_gain;
    slot_route_out.gain == ((w[14:13] == 2'h0) ? 2'h0 : (w[14:13] == 2'h1) ? 2'h1 : 2'h2);
  endproperty
  a_gain: assert property (p_gain) else $error("gain wrong");
  property p_neg;
    !w[3] |-> slot_route_out.neg == {1'b0, w[4]};
  endproperty
  a_neg: assert property (p_neg) else $error("negative input wrong");
  property p_ext;
    !w[3] |-> slot_route_out.pos == w[3:0] && !slot_route_out.internal;
  endproperty
  a_ext: assert property (p_ext) else $error("external input wrong");
  property p_auto;
    w[3] |-> slot_route_out.neg == 2'h2 && slot_route_out.internal;
  endproperty
  a_auto: assert property (p_auto) else $error("negative not automatic");
  property p_int;
    w[3:2] == 2'h2 || w[3:0] == 4'hb |-> slot_route_out.pos == w[3:0];
  endproperty
  a_int: assert property (p_int) else $error("internal source wrong");
  property p_hi;
    w[3:2] == 2'h3 |-> slot_route_out.pos == ((w[1:0] == 2'h0) ? 4'hc : (w[1:0] == 2'h3) ? 4'he : 4'hd);
  endproperty
  a_hi: assert property (p_hi) else $error("supply source wrong");
  property p_resv;
    slot12_config_out[12:5] == 8'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_rst;
    disable iff (1'b0) sys_rst_in |=> slot12_config_out == 16'h000c && slot13_config_out == 16'h000d;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
endmodule : mux_adc_slot_chk
bind mux_adc_slot_config mux_adc_slot_chk u_chk (
  .core_clk_in,
  .sys_rst_in,
  .slot_route_out,
  .slot12_config_out,
  .slot13_config_out
);
`default_nettype wire

//--- tb/tb_top.sv
// testbench: register access and route decode of the slot block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [31:0] d; logic [1:0] r; logic c; logic k; logic [9:0] e;} rexp_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] s12, s13;
  mux_adc_slot_pkg::slot_route_t route;
  logic [1:0] bq[$]; // expected write responses
  rexp_t rq[$]; // expected read results
  rexp_t re;
  int mismatches = 0, compares = 0, i, seed;
  logic [31:0] v;
  logic [15:0] w;
  // 40 mhz clock
  always #12.5 clk = ~clk;
  mux_adc_slot_config u_dut (
    .core_clk_in(clk), .sys_rst_in(rst),
    .s_axi_awaddr_in(awaddr), .s_axi_awprot_in(3'h0), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arprot_in(3'h0), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .slot_route_out(route), .slot12_config_out(s12),
    .slot13_config_out(s13)
  );
  // expected route bits from a slot word
  function automatic logic [9:0] xr(input logic [15:0] x);
    logic [1:0] g;
    logic [3:0] p;
    g = (x[14:13] == 2'h0) ? 2'h0 : (x[14:13] == 2'h1) ? 2'h1 : 2'h2;
    p = (x[3:2] != 2'h3) ? x[3:0] : (x[1:0] == 2'h0) ? 4'hc : (x[1:0] == 2'h3) ? 4'he : 4'hd;
    return {x[15], g, p, (x[3] ? 2'h2 : {1'b0, x[4]}), x[3]};
  endfunction : xr
  task automatic fail(input string m);
    mismatches++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail
  task automatic cmp_b(input logic [1:0] e);
    compares++;
    if (bresp !== e) fail("write response");
  endtask : cmp_b
  task automatic cmp_r(input rexp_t e);
    compares++;
    if (rdata !== e.d || rresp !== e.r) fail("read result");
  endtask : cmp_r
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] e);
    compares++;
    if (got !== e) fail("config word");
  endtask : cmp_word
  task automatic cmp_route(input logic [9:0] e);
    compares++;
    if (route !== e) fail("route");
  endtask : cmp_route
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    logic ap, wp;
    ap = 1'b1;
    wp = 1'b1;
    @(posedge clk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (ap || wp) begin
      @(posedge clk);
      if (ap && awready) begin
        ap = 1'b0;
        awvalid <= 1'b0;
      end
      if (wp && wready) begin
        wp = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
  endtask : wr
  // read: expected data noted, route checked on slot 12 reads
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    rq.push_back('{d, r, a == 12'h370, a == 12'h374, xr(d[15:0])});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
  endtask : rd
  // monitor: compare each answer with the oldest note
  always @(posedge clk) begin
    if (!rst && bvalid && bready) cmp_b(bq.pop_front());
    if (!rst && rvalid && rready) begin
      re = rq.pop_front();
      cmp_r(re);
      if (re.c) cmp_route(re.e);
      if (re.c) cmp_word(s12, re.d[15:0]);
      if (re.k) cmp_word(s13, re.d[15:0]);
    end
  end
  task automatic conclude;
    if (bq.size() != 0 || rq.size() != 0) mismatches++;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // watchdog
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
  // main sequence
  initial begin
    seed = 32'h28c4;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(12'h370, 32'h0000000c, 2'h0);
    rd(12'h374, 32'h0000000d, 2'h0);
    for (i = 0; i < 128; i++) begin
      v = $random(seed);
      w = {v[15], i[6:5], v[12:5], i[4:0]};
      wr(12'h370, {v[31:16], w}, {v[22:21], 2'h3}, 2'h0);
      rd(12'h370, {16'h0, w & 16'he01f}, 2'h0);
    end
    wr(12'h370, 32'h0, 4'hf, 2'h0);
    wr(12'h370, 32'hffff, 4'h1, 2'h0);
    rd(12'h370, 32'h001f, 2'h0);
    wr(12'h370, 32'hffff, 4'h2, 2'h0);
    rd(12'h370, 32'he01f, 2'h0);
    v = $random(seed);
    wr(12'h374, v, 4'hf, 2'h0);
    rd(12'h374, {16'h0, v[15:0]}, 2'h0);
    wr(12'h378, ~v, 4'hf, 2'h2);
    rd(12'h378, 32'h0, 2'h2);
    rd(12'h374, {16'h0, v[15:0]}, 2'h0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(12'h370, 32'h0000000c, 2'h0);
    rd(12'h374, 32'h0000000d, 2'h0);
    @(posedge clk);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
